// file: design/rpt_params.svh
`ifndef RPT_PARAMS_SVH
`define RPT_PARAMS_SVH

// register offsets on the plain register port
`define RPT_REG_CTRL      4'h0
`define RPT_REG_DIV       4'h1
`define RPT_REG_HTIM      4'h2
`define RPT_REG_VTIM      4'h3
`define RPT_REG_SIZE      4'h4
`define RPT_REG_RAW       4'h5
`define RPT_REG_STAT      4'h6

// control register fields
`define RPT_CTRL_START    0
`define RPT_CTRL_PV_EN    1
`define RPT_CTRL_HS_EN    2
`define RPT_CTRL_VS_EN    3
`define RPT_CTRL_MODE_LO  4

// status register fields
`define RPT_STAT_RUN      0
`define RPT_STAT_UNDER    1
`define RPT_STAT_QLVL_LO  2
`define RPT_STAT_REQ      4

// reset values
`define RPT_CTRL_RST      32'h0000_000E
`define RPT_DIV_RST       8'h04
`define RPT_HTIM_RST      24'h05_28_01
`define RPT_VTIM_RST      24'h08_08_01
`define RPT_WIDTH_RST     10'h1E0
`define RPT_HEIGHT_RST    9'h110
`define RPT_PIXBITS_RST   6'h10
`define RPT_BUSBITS_RST   6'h10

// geometry limits
`define RPT_MAX_WIDTH     10'h320
`define RPT_MAX_HEIGHT    9'h1E0
`define RPT_QUEUE_DEPTH   2'h2

// pixel clock limit against the system clock
`define RPT_SYS_KHZ       250000
`define RPT_PCLK_MAX_KHZ  62500
`define RPT_DIV_MIN       ((`RPT_SYS_KHZ + `RPT_PCLK_MAX_KHZ - 1) / `RPT_PCLK_MAX_KHZ)

`endif

// file: design/rpt_pkg.sv
package rpt_pkg;

    // how a fetched pixel word is laid onto the data bus
    typedef enum logic [1:0] {
        RPT_MODE_RGB565 = 2'b00,
        RPT_MODE_RGB888 = 2'b01,
        RPT_MODE_RAW    = 2'b10
    } rpt_mode_t;

    // scan engine state
    typedef enum logic {
        RPT_ST_IDLE = 1'b0,
        RPT_ST_RUN  = 1'b1
    } rpt_state_t;

endpackage

// file: design/rpt_pixel_format.sv
`timescale 1ns/1ns
`default_nettype none
module rpt_pixel_format (
    input  wire rpt_pkg::rpt_mode_t mode,
    input  wire logic [31:0]        pixel,
    input  wire logic [4:0]         beat,
    input  wire logic [5:0]         bus_bits,
    output logic [31:0]             bus_word
);
    import rpt_pkg::*;

    logic [10:0] shift;
    logic [31:0] shifted;
    logic [31:0] mask;

    // raw mode sends bus_bits of the pixel per beat, low bits first
    always_comb begin
        shift   = 11'(beat) * 11'(bus_bits);
        shifted = (shift > 11'h01F) ? 32'h0 : (pixel >> shift[4:0]);
        mask    = (bus_bits >= 6'h20) ? 32'hFFFF_FFFF
                  : ((32'h1 << bus_bits[4:0]) - 32'h1);
        unique case (mode)
            RPT_MODE_RGB565: begin
                bus_word = {16'h0, pixel[23:19], pixel[15:10],
                            pixel[7:3]};
            end
            RPT_MODE_RGB888: begin
                bus_word = {8'h0, pixel[23:16], pixel[15:8],
                            pixel[7:0]};
            end
            RPT_MODE_RAW: begin
                bus_word = shifted & mask;
            end
            default: begin
                bus_word = 32'h0;
            end
        endcase
    end
endmodule
`default_nettype wire

// file: design/rpt_timing_gen.sv
`include "rpt_params.svh"
`timescale 1ns/1ns
`default_nettype none
module rpt_timing_gen (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        sub_valid,
    input  wire logic [31:0] sub_handle,
    output logic             sub_ready,
    output logic             req_valid,
    input  wire logic        req_ack,
    output logic [31:0]      pix_addr,
    input  wire logic [31:0] pix_data,
    output logic             lcd_clk,
    output logic             lcd_clk_oe,
    output logic [31:0]      lcd_data,
    output logic             lcd_data_oe,
    output logic             pixel_valid_strobe,
    output logic             pixel_valid_strobe_oe,
    output logic             line_sync,
    output logic             line_sync_oe,
    output logic             frame_sync,
    output logic             frame_sync_oe
);
    import rpt_pkg::*;

    rpt_state_t  state_q;
    logic [31:0] ctrl_q;
    logic [7:0]  div_q;
    logic [23:0] htim_q;
    logic [23:0] vtim_q;
    logic [9:0]  width_q;
    logic [8:0]  height_q;
    logic [5:0]  pixbits_q;
    logic [5:0]  busbits_q;
    logic        under_q;
    logic [7:0]  div_cnt_q;
    logic [15:0] h_q;
    logic [11:0] v_q;
    logic [4:0]  beat_q;
    logic [31:0] cur_handle_q;
    logic [15:0] fidx_q;
    logic [31:0] qe0_q;
    logic [31:0] qe1_q;
    logic [1:0]  qcnt_q;
    logic [1:0]  qcnt_d;
    logic [2:0]  tok_q;

    rpt_mode_t   mode;
    logic [7:0]  div_eff;
    logic [15:0] hpw, hbp, hfp, hd, hstart, htotal;
    logic [11:0] vpw, vbp, vfp, vd, vstart, vtotal;
    logic [9:0]  width_eff;
    logic [8:0]  height_eff;
    logic [5:0]  pb_eff, bb_eff;
    logic [5:0]  beats;
    logic        tick, h_act, v_act, line_start, last_beat;
    logic        push, pop;
    logic [31:0] fmt_word;

    // configuration decode with limits applied
    always_comb begin
        mode       = rpt_mode_t'(ctrl_q[`RPT_CTRL_MODE_LO +: 2]);
        div_eff    = (div_q < 8'(`RPT_DIV_MIN)) ? 8'(`RPT_DIV_MIN)
                     : div_q;
        width_eff  = (width_q > `RPT_MAX_WIDTH) ? `RPT_MAX_WIDTH
                     : width_q;
        height_eff = (height_q > `RPT_MAX_HEIGHT) ? `RPT_MAX_HEIGHT
                     : height_q;
        pb_eff     = (pixbits_q == 6'h0) ? 6'h01
                     : ((pixbits_q > 6'h20) ? 6'h20 : pixbits_q);
        bb_eff     = (busbits_q == 6'h0) ? 6'h01
                     : ((busbits_q > 6'h20) ? 6'h20 : busbits_q);
        beats      = (mode == RPT_MODE_RAW)
                     ? 6'((pb_eff + bb_eff - 6'h01) / bb_eff)
                     : 6'h01;
        // sync width kept at one or more so a fetch fits before data
        hpw    = (htim_q[7:0] == 8'h0) ? 16'h1 : 16'(htim_q[7:0]);
        hbp    = 16'(htim_q[15:8]);
        hfp    = 16'(htim_q[23:16]);
        hd     = 16'(width_eff) * 16'(beats);
        hstart = hpw + hbp;
        htotal = hstart + hd + hfp;
        vpw    = (vtim_q[7:0] == 8'h0) ? 12'h1 : 12'(vtim_q[7:0]);
        vbp    = 12'(vtim_q[15:8]);
        vfp    = 12'(vtim_q[23:16]);
        vd     = 12'(height_eff);
        vstart = vpw + vbp;
        vtotal = vstart + vd + vfp;
    end

    // position decode; one tick per pixel clock period
    assign tick       = (state_q == RPT_ST_RUN) && div_cnt_q == div_eff - 8'h1;
    assign h_act      = (h_q >= hstart) && (h_q < hstart + hd);
    assign v_act      = (v_q >= vstart) && (v_q < vstart + vd);
    assign line_start = tick && (h_q == 16'h0);
    assign last_beat  = (6'(beat_q) == beats - 6'h01);
    assign push       = sub_valid && sub_ready;
    assign pop        = line_start && v_act && (qcnt_q != 2'h0);

    rpt_pixel_format u_fmt (
        .mode     (mode),
        .pixel    (pix_data),
        .beat     (beat_q),
        .bus_bits (bb_eff),
        .bus_word (fmt_word)
    );

    // register writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q    <= `RPT_CTRL_RST;
            div_q     <= `RPT_DIV_RST;
            htim_q    <= `RPT_HTIM_RST;
            vtim_q    <= `RPT_VTIM_RST;
            width_q   <= `RPT_WIDTH_RST;
            height_q  <= `RPT_HEIGHT_RST;
            pixbits_q <= `RPT_PIXBITS_RST;
            busbits_q <= `RPT_BUSBITS_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `RPT_REG_CTRL: ctrl_q <= {26'h0, reg_wdata[5:0]};
                `RPT_REG_DIV:  div_q  <= reg_wdata[7:0];
                `RPT_REG_HTIM: htim_q <= reg_wdata[23:0];
                `RPT_REG_VTIM: vtim_q <= reg_wdata[23:0];
                `RPT_REG_SIZE: begin
                    width_q  <= reg_wdata[9:0];
                    height_q <= reg_wdata[24:16];
                end
                `RPT_REG_RAW: begin
                    pixbits_q <= reg_wdata[5:0];
                    busbits_q <= reg_wdata[13:8];
                end
                default: ;
            endcase
        end
    end

    // register reads, data in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `RPT_REG_CTRL: reg_rdata <= ctrl_q;
                `RPT_REG_DIV:  reg_rdata <= {24'h0, div_q};
                `RPT_REG_HTIM: reg_rdata <= {8'h0, htim_q};
                `RPT_REG_VTIM: reg_rdata <= {8'h0, vtim_q};
                `RPT_REG_SIZE: reg_rdata <= {7'h0, height_q, 6'h0, width_q};
                `RPT_REG_RAW:  reg_rdata <= {18'h0, busbits_q, 2'h0,
                                             pixbits_q};
                `RPT_REG_STAT: reg_rdata <= {27'h0, req_valid, qcnt_q,
                                             under_q,
                                             state_q == RPT_ST_RUN};
                default:       reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // run state follows the start bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= RPT_ST_IDLE;
        end else begin
            unique case (state_q)
                RPT_ST_IDLE: if (ctrl_q[`RPT_CTRL_START]) state_q <= RPT_ST_RUN;
                RPT_ST_RUN:  if (!ctrl_q[`RPT_CTRL_START]) state_q <= RPT_ST_IDLE;
            endcase
        end
    end

    // clock divider and panel clock, high in the second half of a period
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_cnt_q  <= 8'h0;
            lcd_clk    <= 1'b0;
            lcd_clk_oe <= 1'b0;
        end else if (state_q != RPT_ST_RUN) begin
            div_cnt_q  <= 8'h0;
            lcd_clk    <= 1'b0;
            lcd_clk_oe <= 1'b0;
        end else begin
            lcd_clk_oe <= 1'b1;
            if (tick) begin
                div_cnt_q <= 8'h0;
                lcd_clk   <= 1'b0;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h1;
                lcd_clk   <= (div_cnt_q + 8'h1) >= (div_eff >> 1);
            end
        end
    end

    // horizontal and vertical counters
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            h_q <= 16'h0;
            v_q <= 12'h0;
        end else if (state_q != RPT_ST_RUN) begin
            h_q <= 16'h0;
            v_q <= 12'h0;
        end else if (tick) begin
            if (h_q >= htotal - 16'h1) begin
                h_q <= 16'h0;
                v_q <= (v_q >= vtotal - 12'h1) ? 12'h0
                       : v_q + 12'h1;
            end else begin
                h_q <= h_q + 16'h1;
            end
        end
    end

    // panel outputs, all updated on the falling pixel clock edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lcd_data              <= 32'h0;
            lcd_data_oe           <= 1'b0;
            pixel_valid_strobe    <= 1'b0;
            pixel_valid_strobe_oe <= 1'b0;
            line_sync             <= 1'b0;
            line_sync_oe          <= 1'b0;
            frame_sync            <= 1'b0;
            frame_sync_oe         <= 1'b0;
        end else if (state_q != RPT_ST_RUN) begin
            lcd_data              <= 32'h0;
            lcd_data_oe           <= 1'b0;
            pixel_valid_strobe    <= 1'b0;
            pixel_valid_strobe_oe <= 1'b0;
            line_sync             <= 1'b0;
            line_sync_oe          <= 1'b0;
            frame_sync            <= 1'b0;
            frame_sync_oe         <= 1'b0;
        end else if (tick) begin
            lcd_data_oe           <= 1'b1;
            pixel_valid_strobe_oe <= ctrl_q[`RPT_CTRL_PV_EN];
            line_sync_oe          <= ctrl_q[`RPT_CTRL_HS_EN];
            frame_sync_oe         <= ctrl_q[`RPT_CTRL_VS_EN];
            lcd_data <= (h_act && v_act) ? fmt_word : 32'h0;
            pixel_valid_strobe <= ctrl_q[`RPT_CTRL_PV_EN] && h_act
                                  && v_act;
            line_sync  <= ctrl_q[`RPT_CTRL_HS_EN] && (h_q < hpw);
            frame_sync <= ctrl_q[`RPT_CTRL_VS_EN] && (v_q < vpw);
        end
    end

    // pixel fetch index and beat within a serialised pixel
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            beat_q <= 5'h0;
            fidx_q <= 16'h0;
        end else if (line_start || state_q != RPT_ST_RUN) begin
            beat_q <= 5'h0;
            fidx_q <= 16'h0;
        end else if (tick && h_act && v_act) begin
            if (last_beat) begin
                beat_q <= 5'h0;
                fidx_q <= fidx_q + 16'h1;
            end else begin
                beat_q <= beat_q + 5'h1;
            end
        end
    end

    // fetch address for the pixel shown at the next tick
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pix_addr <= 32'h0;
        end else begin
            pix_addr <= cur_handle_q + 32'(fidx_q);
        end
    end

    // two-entry submission queue; oldest entry in qe0
    always_comb begin
        qcnt_d = qcnt_q;
        if (push && !pop) begin
            qcnt_d = qcnt_q + 2'h1;
        end else if (pop && !push) begin
            qcnt_d = qcnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            qe0_q        <= 32'h0;
            qe1_q        <= 32'h0;
            qcnt_q       <= 2'h0;
            sub_ready    <= 1'b0;
            cur_handle_q <= 32'h0;
        end else begin
            qcnt_q    <= qcnt_d;
            sub_ready <= (qcnt_d < `RPT_QUEUE_DEPTH);
            if (pop) begin
                cur_handle_q <= qe0_q;
                qe0_q <= (push && qcnt_q == 2'h1) ? sub_handle : qe1_q;
                if (push && qcnt_q == 2'h2) begin
                    qe1_q <= sub_handle;
                end
            end else if (push) begin
                if (qcnt_q == 2'h0) begin
                    qe0_q <= sub_handle;
                end else begin
                    qe1_q <= sub_handle;
                end
            end
        end
    end

    // request tokens: one per line buffer consumed, taken by acknowledge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tok_q     <= 3'h0;
            req_valid <= 1'b0;
        end else if (state_q != RPT_ST_RUN) begin
            tok_q     <= 3'h0;
            req_valid <= 1'b0;
        end else begin
            if (line_start && v_act && !(req_ack && tok_q != 3'h0)) begin
                tok_q     <= (tok_q == 3'h7) ? tok_q : tok_q + 3'h1;
                req_valid <= 1'b1;
            end else if (req_ack && req_valid && !(line_start && v_act)) begin
                tok_q     <= tok_q - 3'h1;
                req_valid <= (tok_q != 3'h1);
            end
        end
    end

    // sticky underrun: a line began with an empty queue
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            under_q <= 1'b0;
        end else if (line_start && v_act && qcnt_q == 2'h0) begin
            under_q <= 1'b1;
        end else if (reg_wr && reg_addr == `RPT_REG_STAT
                     && reg_wdata[`RPT_STAT_UNDER]) begin
            under_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: verification/rpt_timing_gen_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rpt_timing_gen_sva (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        sub_valid,
    input wire logic        sub_ready,
    input wire logic        req_valid,
    input wire logic        lcd_clk,
    input wire logic        lcd_clk_oe,
    input wire logic [31:0] lcd_data,
    input wire logic        lcd_data_oe,
    input wire logic        pixel_valid_strobe,
    input wire logic        pixel_valid_strobe_oe,
    input wire logic        line_sync,
    input wire logic        line_sync_oe,
    input wire logic        frame_sync,
    input wire logic        frame_sync_oe
);
    logic ls_seen_q;

    // one clock domain, checks quiet while in reset
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // remembers a line-sync pulse since the last pixel burst began
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ls_seen_q <= 1'b0;
        end else if ($rose(line_sync)) begin
            ls_seen_q <= 1'b1;
        end else if ($rose(pixel_valid_strobe) || !lcd_clk_oe) begin
            ls_seen_q <= 1'b0;
        end
    end

    // idle: clock low and every panel pin released
    property p_idle;
        !lcd_clk_oe |-> !lcd_clk && !lcd_data_oe && !pixel_valid_strobe_oe
            && !line_sync_oe && !frame_sync_oe;
    endproperty
    a_idle: assert property (p_idle)
        else $error("panel pins driven while idle");

    // a start write gets the pixel clock pin driven soon
    property p_start;
        reg_wr && reg_addr == 4'h0 && reg_wdata[0] |-> ##[1:3] lcd_clk_oe;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not drive the pixel clock");

    // pixel clock period never below four system clocks
    property p_clk_max;
        $rose(lcd_clk) |=> !$rose(lcd_clk) [*3];
    endproperty
    a_clk_max: assert property (p_clk_max)
        else $error("pixel clock too fast");

    // data and strobes move only with the falling pixel clock
    property p_sync_chg;
        lcd_clk_oe && $past(lcd_clk_oe) && ($changed(lcd_data)
            || $changed(pixel_valid_strobe) || $changed(line_sync)
            || $changed(frame_sync)) |-> $fell(lcd_clk);
    endproperty
    a_sync_chg: assert property (p_sync_chg)
        else $error("panel output moved off the pixel clock");

    // bus is zero whenever the valid strobe is driven and low
    property p_pv_zero;
        pixel_valid_strobe_oe && !pixel_valid_strobe |-> lcd_data == 32'h0;
    endproperty
    a_pv_zero: assert property (p_pv_zero)
        else $error("data on the bus without valid strobe");

    // a porch of at least one pixel follows every burst
    property p_gap;
        $fell(pixel_valid_strobe) |-> !pixel_valid_strobe [*4];
    endproperty
    a_gap: assert property (p_gap)
        else $error("no porch after active pixels");

    // sync intervals carry no pixels
    property p_excl;
        line_sync || frame_sync |-> !pixel_valid_strobe;
    endproperty
    a_excl: assert property (p_excl)
        else $error("pixels during a sync pulse");

    // with line sync driven, every pixel burst is preceded by its own line-sync pulse
    property p_ls_first;
        $rose(pixel_valid_strobe) && line_sync_oe |-> ls_seen_q;
    endproperty
    a_ls_first: assert property (p_ls_first)
        else $error("pixel burst without line sync");

    // a frame starts on a line start
    property p_fs_ls;
        $rose(frame_sync) && line_sync_oe |-> $rose(line_sync);
    endproperty
    a_fs_ls: assert property (p_fs_ls)
        else $error("frame sync off a line start");

    // queue refuses only after a push filled it
    property p_full;
        $fell(sub_ready) |-> $past(sub_valid);
    endproperty
    a_full: assert property (p_full)
        else $error("queue closed without a push");

    // a request token appears only on a line-start pixel tick
    property p_req_tick;
        $rose(req_valid) |-> $fell(lcd_clk) && (line_sync || !line_sync_oe);
    endproperty
    a_req_tick: assert property (p_req_tick)
        else $error("request token off a line start");
endmodule

bind rpt_timing_gen rpt_timing_gen_sva u_sva (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sub_valid(sub_valid),
    .sub_ready(sub_ready), .req_valid(req_valid), .lcd_clk(lcd_clk),
    .lcd_clk_oe(lcd_clk_oe), .lcd_data(lcd_data), .lcd_data_oe(lcd_data_oe),
    .pixel_valid_strobe(pixel_valid_strobe),
    .pixel_valid_strobe_oe(pixel_valid_strobe_oe),
    .line_sync(line_sync), .line_sync_oe(line_sync_oe),
    .frame_sync(frame_sync), .frame_sync_oe(frame_sync_oe)
);
`default_nettype wire

// file: verification/rpt_panel_model.sv
`timescale 1ns/1ns
`default_nettype none
module rpt_panel_model (
    input  wire logic        lcd_clk,
    input  wire logic [31:0] lcd_data,
    input  wire logic        pixel_valid_strobe,
    output logic [31:0]      pix_word,
    output logic             pix_tgl
);
    logic [31:0] word_q = 32'h0;
    logic        tgl_q  = 1'b0;

    // latch on the rising pixel clock, a toggle marks each new pixel
    always @(posedge lcd_clk) begin
        if (pixel_valid_strobe) begin
            word_q <= lcd_data;
            tgl_q  <= !tgl_q;
        end
    end

    assign pix_word = word_q;
    assign pix_tgl  = tgl_q;
endmodule
`default_nettype wire

// file: verification/tb_rgb_panel_timing_generator.sv
`timescale 1ns/1ns
`default_nettype none
module tb_rgb_panel_timing_generator;
    logic        clk_sys, rst, reg_wr, reg_rd, sub_valid, req_ack, stall;
    logic        sub_ready, req_valid, lcd_clk, lcd_clk_oe, lcd_data_oe;
    logic        pv, pv_oe, ls, ls_oe, fs, fs_oe, pix_tgl, tgl_q;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, sub_handle, pix_data, salt, reg_rdata;
    logic [31:0] pix_addr, lcd_data, pix_word;
    logic [31:0] hq[$], gq[$], eq[$];
    int          errors, compares, acks, n;
    logic [31:0] rv[8] = '{32'hE, 32'h4, 32'h52801, 32'h80801,
                           32'h11001E0, 32'h1010, 32'h0, 32'h0};
    logic [31:0] dv[3] = '{32'h2, 32'h6, 32'h5};
    logic [2:0]  en[3] = '{3'h7, 3'h1, 3'h5};
    int          pe[3] = '{4, 6, 5};

    rpt_timing_gen DUT (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sub_valid(sub_valid),
        .sub_handle(sub_handle), .sub_ready(sub_ready),
        .req_valid(req_valid), .req_ack(req_ack), .pix_addr(pix_addr),
        .pix_data(pix_data), .lcd_clk(lcd_clk), .lcd_clk_oe(lcd_clk_oe),
        .lcd_data(lcd_data), .lcd_data_oe(lcd_data_oe),
        .pixel_valid_strobe(pv), .pixel_valid_strobe_oe(pv_oe),
        .line_sync(ls), .line_sync_oe(ls_oe),
        .frame_sync(fs), .frame_sync_oe(fs_oe)
    );

    rpt_panel_model u_panel (
        .lcd_clk(lcd_clk), .lcd_data(lcd_data), .pixel_valid_strobe(pv),
        .pix_word(pix_word), .pix_tgl(pix_tgl)
    );

    always #2 clk_sys = !clk_sys;

    // pixel memory seen by the design, salted at random
    function automatic logic [31:0] pixf(logic [31:0] a);
        return (a * 32'h9E37_79B1) ^ salt;
    endfunction
    assign pix_data = pixf(pix_addr);

    // client: keeps the queue topped up, acks tokens late at random
    always @(posedge clk_sys) begin
        if (sub_valid && sub_ready) begin
            hq.push_back(sub_handle);
            sub_handle <= $urandom & 32'h00FF_FF00;
        end
        sub_valid <= !rst && !stall;
        if (req_valid && req_ack) acks++;
        req_ack <= req_valid && $urandom_range(1);
        if (pix_tgl !== tgl_q) gq.push_back(pix_word);
        tgl_q <= pix_tgl;
    end

    task automatic cmp(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(logic [3:0] a, logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask

    // counts system clocks from one pixel clock rise to the next
    task automatic clk_period(output int c);
        c = 0;
        for (int p = 0; p < 4; p++) begin
            if (p == 2) c = 0;
            while (lcd_clk !== p[0] && c < 99) begin
                @(posedge clk_sys);
                c++;
            end
        end
    endtask

    task automatic wait_pix(int need);
        for (int k = 0; k < 5000 && gq.size() < need; k++) @(posedge clk_sys);
        if (gq.size() < need) begin
            errors++;
            final_report();
        end
    endtask

    // model of one 4 x 3 frame as the panel should see it
    task automatic expect_frame(int m);
        logic [31:0] p, b;
        for (int l = 0; l < 3; l++) begin
            b = hq.pop_front();
            for (int i = 0; i < 4; i++) begin
                p = pixf(b + i);
                if (m == 0) begin
                    eq.push_back({16'h0, p[23:19], p[15:10], p[7:3]});
                end else if (m == 1) begin
                    eq.push_back({8'h0, p[23:0]});
                end else begin
                    eq.push_back({24'h0, p[7:0]});
                    eq.push_back({24'h0, p[15:8]});
                end
            end
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {reg_wr, reg_rd, req_ack, sub_valid, tgl_q} = 5'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        sub_handle = 32'h100;
        stall = 1'b1;
        errors = 0;
        compares = 0;
        acks = 0;
        salt = $urandom(32'hD9BE);
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values and an unmapped index, nothing running yet
        for (int i = 0; i < 8; i++) rd(i[3:0], rv[i]);
        cmp({29'h0, lcd_clk, lcd_clk_oe, lcd_data_oe}, 32'h0);
        wr(4'h2, 32'h0002_0302);
        wr(4'h3, 32'h0001_0201);
        wr(4'h4, 32'h0003_0004);
        wr(4'h5, 32'h0000_0810);
        stall <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rd(4'h6, 32'h0000_0008);
        // one frame per output mode, each with its own strobe subset
        for (int m = 0; m < 3; m++) begin
            wr(4'h1, dv[m]);
            wr(4'h0, {26'h0, m[1:0], en[m], 1'b1});
            clk_period(n);
            cmp(n, pe[m]);
            cmp({29'h0, fs_oe, ls_oe, pv_oe}, {29'h0, en[m]});
            if (m == 0) begin
                wait_pix(1);
                stall <= 1'b1;
                repeat (100) @(posedge clk_sys);
                stall <= 1'b0;
            end
            wait_pix(m == 2 ? 24 : 12);
            wr(4'h0, 32'h0);
            repeat (40) @(posedge clk_sys);
            expect_frame(m);
            cmp(gq.size(), eq.size());
            while (eq.size() > 0 && gq.size() > 0) begin
                cmp(gq.pop_front(), eq.pop_front());
            end
            gq.delete();
            eq.delete();
            cmp(acks, 3 * (m + 1));
            rd(4'h6, 32'h0000_0008);
        end
        // client goes quiet while running: queue drains, underrun sticks
        stall <= 1'b1;
        wr(4'h0, 32'h0000_0003);
        repeat (400) @(posedge clk_sys);
        wr(4'h0, 32'h0);
        rd(4'h6, 32'h0000_0002);
        wr(4'h6, 32'h0000_0002);
        rd(4'h6, 32'h0000_0000);
        final_report();
    end
endmodule
`default_nettype wire
